/* logic/word_table_push_pop_engine.sv */
/*
  Table push/pop engine: once per scan, pops the top table word to a destination word
  or pushes a source word onto the top, keeping the counter word at the table base.
  Assumes a word memory answering a read one cycle later with mem_rvalid_in, taking
  one request per cycle while mem_ready_in is high, and a scan sequencer that pulses
  scan_start_in at a scan's start and scan_end_in at its end.
*/
// Function
// - Pop takes one value out of the table into the destination word.
// - After pop, remaining entries move one place toward the table start.
// - Word at base address is the counter; data starts at base plus one.
// - Each executed pop decreases the counter word by one.
// - Pop with counter zero or above length is skipped and flag set.
// - Operation runs once per scan while the rung enable is true.
// - Operand names pop destination or push source word.
// - Counter outside 1 to length moves no data.
// - Flag set when counter word equals zero after the operation.
// - Flag holds only until next flag-driving operation or end of scan.
// - Entries numbered from top; entries beyond counter stay unmoved.
// - Push copies the source word into the top entry.
// - Push first moves existing entries one place further from start.
// - Each executed push increases the counter word by one.
// - Pushes allowed equal length minus counter; refused at length.
// - Push with counter zero or out of range writes no data.
`timescale 1ns/100ps
`default_nettype none

module word_table_push_pop_engine #(
  parameter int unsigned WORD_W = word_table_pkg::WORD_W,
  parameter int unsigned ADDR_W = word_table_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Scan sequencer
  input wire logic scan_start_in,
  input wire logic scan_end_in,
  input wire logic rung_enable_in,
  input wire word_table_pkg::op_args_t args_in,
  output logic done_out,
  output logic table_counter_zero_flag_out,
  // Word memory
  output word_table_pkg::mem_req_t mem_req_out,
  input wire logic mem_ready_in,
  input wire logic mem_rvalid_in,
  input wire logic [WORD_W-1:0] mem_rdata_in
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  // Whole engine state, registered once per clock
  typedef struct packed {
    word_table_pkg::eng_state_t st;
    logic ran;
    word_table_pkg::op_args_t args;
    logic [WORD_W-1:0] cnt;
    logic [ADDR_W-1:0] idx;
    logic [WORD_W-1:0] top;
    logic wait_rd;
    logic [1:0] buf_cnt;
    logic [WORD_W-1:0] buf0;
    logic [WORD_W-1:0] buf1;
    logic [1:0] wr_phase;
    word_table_pkg::mem_req_t req;
    logic done;
    logic flag;
  } eng_t;

  eng_t state_reg;
  eng_t state_next;

  // Address of table entry k, counted from the counter word
  function automatic logic [ADDR_W-1:0] entry_addr(input logic [ADDR_W-1:0] base,
                                                    input logic [ADDR_W-1:0] k);
    entry_addr = ADDR_W'(base + k);
  endfunction : entry_addr

  // Decodes the operation code for ST_CHECK and ST_RD_MOVE; other states compare with OP_POP directly
  function automatic logic is_pop(input word_table_pkg::table_op_t op);
    is_pop = (op == word_table_pkg::OP_POP);
  endfunction : is_pop

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  logic buf_in_ready;
  logic buf_out_valid;
  logic [WORD_W-1:0] buf_head;
  logic can_issue;
  logic in_range;
  logic buf_push;
  logic buf_pop;

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.req.rd = 1'b0;
    state_next.req.wr = 1'b0;
    // Two-entry buffer between read data and writes
    buf_in_ready = (state_reg.buf_cnt != 2'd2);
    buf_out_valid = (state_reg.buf_cnt != 2'd0);
    buf_head = state_reg.buf0;
    buf_push = mem_rvalid_in && state_reg.wait_rd && buf_in_ready &&
               (state_reg.st == word_table_pkg::ST_WR_MOVE);
    buf_pop = 1'b0;
    can_issue = mem_ready_in || !(state_reg.req.rd || state_reg.req.wr);
    // Counter must lie in 1..length for any data to move
    in_range = (state_reg.cnt != word_table_pkg::WORD_ZERO) &&
               (state_reg.cnt <= WORD_W'(state_reg.args.length));
    // A request stays on the bus until the memory takes it
    if (!can_issue) begin
      state_next.req = state_reg.req;
    end
    if (mem_rvalid_in && state_reg.wait_rd) begin
      state_next.wait_rd = 1'b0;
    end
    // A new scan re-arms the once-per-scan run
    if (scan_start_in) begin
      state_next.ran = 1'b0;
    end
    if (scan_end_in) begin
      state_next.flag = 1'b0;
    end
    unique case (state_reg.st)
      word_table_pkg::ST_IDLE: begin
        // Start needs the rung, a fresh scan and no start strobe this cycle
        if (rung_enable_in && !state_reg.ran && !scan_start_in) begin
          state_next.args = args_in;
          state_next.ran = 1'b1;
          state_next.req.rd = 1'b1;
          state_next.req.addr = args_in.base;
          state_next.wait_rd = 1'b1;
          state_next.st = word_table_pkg::ST_RD_CNT;
        end
      end
      word_table_pkg::ST_RD_CNT: begin
        // Counter word arrives one cycle after its read is taken
        if (mem_rvalid_in && state_reg.wait_rd) begin
          state_next.cnt = mem_rdata_in;
          state_next.st = word_table_pkg::ST_CHECK;
        end
      end
      word_table_pkg::ST_CHECK: begin
        state_next.buf_cnt = 2'd0;
        // Out-of-range counters skip the whole operation and move nothing
        if (!in_range) begin
          state_next.flag = 1'b1;
          state_next.st = word_table_pkg::ST_DONE;
        end else if (!is_pop(state_reg.args.op) &&
                     state_reg.cnt >= WORD_W'(state_reg.args.length)) begin
          state_next.flag = 1'b0;
          state_next.st = word_table_pkg::ST_DONE;
        end else if (can_issue) begin
          state_next.req.rd = 1'b1;
          state_next.wait_rd = 1'b1;
          if (state_reg.args.op == word_table_pkg::OP_POP) begin
            state_next.req.addr = entry_addr(state_reg.args.base,
                                             word_table_pkg::ADDR_ONE);
            state_next.idx = word_table_pkg::ADDR_ONE;
          end else begin
            state_next.req.addr = state_reg.args.operand;
            state_next.idx = ADDR_W'(state_reg.cnt);
          end
          state_next.st = word_table_pkg::ST_RD_SRC;
        end
      end
      word_table_pkg::ST_RD_SRC: begin
        // Popped word or push source waits here until the phase 0 write in ST_WR_END
        if (mem_rvalid_in && state_reg.wait_rd) begin
          state_next.top = mem_rdata_in;
          state_next.st = word_table_pkg::ST_RD_MOVE;
        end
      end
      word_table_pkg::ST_RD_MOVE: begin
        // Pop reads entry idx+1 for slot idx; push reads entry idx for slot idx+1
        if (is_pop(state_reg.args.op) &&
            state_reg.idx >= ADDR_W'(state_reg.cnt)) begin
          state_next.st = word_table_pkg::ST_WR_END;
          state_next.wr_phase = 2'd0;
        end else if (!is_pop(state_reg.args.op) &&
                     state_reg.idx == '0) begin
          state_next.st = word_table_pkg::ST_WR_END;
          state_next.wr_phase = 2'd0;
        end else if (can_issue && buf_in_ready) begin
          state_next.req.rd = 1'b1;
          state_next.wait_rd = 1'b1;
          state_next.req.addr = is_pop(state_reg.args.op) ?
              entry_addr(state_reg.args.base, ADDR_W'(state_reg.idx + 1'b1)) :
              entry_addr(state_reg.args.base, state_reg.idx);
          state_next.st = word_table_pkg::ST_WR_MOVE;
        end
      end
      word_table_pkg::ST_WR_MOVE: begin
        // Read data joins the buffer below; the head leaves as the move write
        if (buf_out_valid && can_issue) begin
          buf_pop = 1'b1;
          state_next.req.wr = 1'b1;
          state_next.req.wdata = buf_head;
          if (state_reg.args.op == word_table_pkg::OP_POP) begin
            state_next.req.addr = entry_addr(state_reg.args.base, state_reg.idx);
            state_next.idx = ADDR_W'(state_reg.idx + 1'b1);
          end else begin
            state_next.req.addr = entry_addr(state_reg.args.base,
                                             ADDR_W'(state_reg.idx + 1'b1));
            state_next.idx = ADDR_W'(state_reg.idx - 1'b1);
          end
          state_next.st = word_table_pkg::ST_RD_MOVE;
        end
      end
      word_table_pkg::ST_WR_END: begin
        // Phase 0 writes the popped word or the push source word, phase 1 the counter, then the flag settles
        if (can_issue) begin
          unique case (state_reg.wr_phase)
            2'd0: begin
              state_next.req.wr = 1'b1;
              if (state_reg.args.op == word_table_pkg::OP_POP) begin
                state_next.req.addr = state_reg.args.operand;
                state_next.req.wdata = state_reg.top;
              end else begin
                state_next.req.addr = entry_addr(state_reg.args.base,
                                                 word_table_pkg::ADDR_ONE);
                state_next.req.wdata = state_reg.top;
              end
              state_next.wr_phase = 2'd1;
            end
            2'd1: begin
              state_next.req.wr = 1'b1;
              state_next.req.addr = state_reg.args.base;
              if (state_reg.args.op == word_table_pkg::OP_POP) begin
                state_next.cnt = WORD_W'(state_reg.cnt - word_table_pkg::WORD_ONE);
                state_next.req.wdata = WORD_W'(state_reg.cnt - word_table_pkg::WORD_ONE);
              end else begin
                state_next.cnt = WORD_W'(state_reg.cnt + word_table_pkg::WORD_ONE);
                state_next.req.wdata = WORD_W'(state_reg.cnt + word_table_pkg::WORD_ONE);
              end
              state_next.wr_phase = 2'd2;
            end
            default: begin
              state_next.flag = (state_reg.cnt == word_table_pkg::WORD_ZERO);
              state_next.st = word_table_pkg::ST_DONE;
            end
          endcase
        end
      end
      word_table_pkg::ST_DONE: begin
        // Done only once the last write has been taken
        if (can_issue) begin
          state_next.done = 1'b1;
          state_next.st = word_table_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next.st = word_table_pkg::ST_IDLE;
      end
    endcase
    // Two-entry buffer between read data and move writes, so a stall loses no word
    if (buf_pop) begin
      state_next.buf0 = state_reg.buf1;
    end
    if (buf_push) begin
      if (state_reg.buf_cnt == 2'd0 || (buf_pop && state_reg.buf_cnt == 2'd1)) begin
        state_next.buf0 = mem_rdata_in;
      end else begin
        state_next.buf1 = mem_rdata_in;
      end
    end
    if (buf_push && !buf_pop) begin
      state_next.buf_cnt = 2'(state_reg.buf_cnt + 2'd1);
    end else if (buf_pop && !buf_push) begin
      state_next.buf_cnt = 2'(state_reg.buf_cnt - 2'd1);
    end
    if (scan_end_in && state_reg.st == word_table_pkg::ST_IDLE) begin
      state_next.flag = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    // Reset leaves the engine idle with every output low
    if (!rst_n_in) begin
      state_reg <= '{st: word_table_pkg::ST_IDLE, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign done_out = state_reg.done;
  assign table_counter_zero_flag_out = state_reg.flag;
  assign mem_req_out = state_reg.req;

endmodule : word_table_push_pop_engine

`default_nettype wire

/* logic/word_table_pkg.sv */
/*
  Package for the table push/pop engine: widths, state codes and carrier structs.
  Assumes one 40 MHz clock domain and a word memory with a one-cycle read latency.
*/
package word_table_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned LEN_W = 8;
  localparam logic [LEN_W-1:0] LEN_MAX = 8'hFF;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
  localparam logic [WORD_W-1:0] WORD_ONE = 16'h0001;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam int unsigned BUF_DEPTH = 2;

  // Operation selection
  typedef enum logic [0:0] {
    OP_POP = 1'b0,
    OP_PUSH = 1'b1
  } table_op_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_RD_CNT = 8'h02,
    ST_CHECK = 8'h04,
    ST_RD_SRC = 8'h08,
    ST_RD_MOVE = 8'h10,
    ST_WR_MOVE = 8'h20,
    ST_WR_END = 8'h40,
    ST_DONE = 8'h80
  } eng_state_t;

  // One request to the word memory
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mem_req_t;

  // Parameters taken from the accumulator stack and the instruction
  typedef struct packed {
    table_op_t op;
    logic [LEN_W-1:0] length;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] operand;
  } op_args_t;

endpackage : word_table_pkg

/* tb/word_table_assertions.sv */
/* Port checker for the table push/pop engine.
   Assumes args_in is held steady while an operation runs. */
`timescale 1ns/100ps
`default_nettype none
module word_table_assertions (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Scan side
  input wire logic scan_start_in,
  input wire logic scan_end_in,
  input wire word_table_pkg::op_args_t args_in,
  input wire logic done_out,
  input wire logic table_counter_zero_flag_out,
  // Memory side
  input wire word_table_pkg::mem_req_t mem_req_out,
  input wire logic mem_ready_in
);
  logic seen_reg;
  logic seen_next;
  logic [16:0] rel;
  logic in_range;
  always_comb begin
    seen_next = scan_start_in ? 1'b0 : (seen_reg | done_out);
    rel = {1'b0, mem_req_out.addr} - {1'b0, args_in.base};
    in_range = (rel <= 17'(args_in.length)) || (mem_req_out.addr == args_in.operand);
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) seen_reg <= 1'b0;
    else seen_reg <= seen_next;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  done_pulse_a:
    assert property (done_out |=> !done_out) else $error("done longer than a cycle");
  req_hold_a:
    assert property ((mem_req_out.rd || mem_req_out.wr) && !mem_ready_in |=>
      $stable(mem_req_out)) else $error("request changed before accept");
  rw_excl_a:
    assert property (!(mem_req_out.rd && mem_req_out.wr)) else $error("read and write at once");
  reset_quiet_a:
    assert property ($rose(rst_n_in) |-> !done_out && mem_req_out == '0)
      else $error("activity right after reset");
  flag_hold_a:
    assert property ($changed(table_counter_zero_flag_out) && !$past(scan_end_in) |=> done_out)
      else $error("flag changed without cause");
  flag_clear_a:
    assert property (scan_end_in ##1 !done_out |-> !table_counter_zero_flag_out)
      else $error("flag kept past scan end");
  once_scan_a:
    assert property (done_out |-> !seen_reg) else $error("second run in one scan");
  wr_range_a:
    assert property (mem_req_out.wr |-> in_range) else $error("write outside table");
  rd_range_a:
    assert property (mem_req_out.rd |-> in_range) else $error("read outside table");
  done_idle_a:
    assert property (done_out |-> !mem_req_out.rd && !mem_req_out.wr)
      else $error("done with access pending");
endmodule : word_table_assertions
bind word_table_push_pop_engine word_table_assertions word_table_assertions_i (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .scan_start_in(scan_start_in),
  .scan_end_in(scan_end_in), .args_in(args_in), .done_out(done_out),
  .table_counter_zero_flag_out(table_counter_zero_flag_out),
  .mem_req_out(mem_req_out), .mem_ready_in(mem_ready_in));
`default_nettype wire

/* tb/word_memory_model.sv */
/* Word memory model facing the engine.
   Assumes one request per cycle; read data one cycle after acceptance. */
`timescale 1ns/100ps
`default_nettype none
module word_memory_model (
  // Clock
  input wire logic ref_clk_in,
  // Requests and answers
  input wire word_table_pkg::mem_req_t mem_req_in,
  output logic mem_ready_out,
  output logic mem_rvalid_out,
  output logic [15:0] mem_rdata_out
);
  logic [15:0] mem [0:65535];
  logic take_rd;
  assign take_rd = mem_req_in.rd && mem_ready_out;
  initial begin
    mem_ready_out = 1'b1;
    mem_rvalid_out = 1'b0;
    mem_rdata_out = 16'h0000;
  end
  // Random stalls; stale data is inverted so it never looks valid
  always @(posedge ref_clk_in) begin
    mem_rvalid_out <= take_rd;
    mem_rdata_out <= take_rd ? mem[mem_req_in.addr] : ~mem_rdata_out;
    if (mem_req_in.wr && mem_ready_out) mem[mem_req_in.addr] <= mem_req_in.wdata;
    mem_ready_out <= ($urandom % 4) != 0;
  end
endmodule : word_memory_model
`default_nettype wire

/* tb/word_table_push_pop_engine_test.sv */
/* Self-checking bench for the table push/pop engine.
   Assumes the memory model and the bound checker beside it. */
`timescale 1ns/100ps
`default_nettype none
module word_table_push_pop_engine_test;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic scan_start_in = 1'b0;
  logic scan_end_in = 1'b0;
  logic rung_enable_in = 1'b0;
  word_table_pkg::op_args_t args_in = '0;
  logic done_out;
  logic table_counter_zero_flag_out;
  word_table_pkg::mem_req_t mem_req_out;
  logic mem_ready_in;
  logic mem_rvalid_in;
  logic [15:0] mem_rdata_in;
  int n_fail = 0;
  int num_checks = 0;
  int ref_mem [int];
  int i;
  int n;
  always #12.5 ref_clk_in = ~ref_clk_in;
  word_table_push_pop_engine word_table_push_pop_engine_i (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .scan_start_in(scan_start_in),
    .scan_end_in(scan_end_in), .rung_enable_in(rung_enable_in), .args_in(args_in),
    .done_out(done_out), .table_counter_zero_flag_out(table_counter_zero_flag_out),
    .mem_req_out(mem_req_out), .mem_ready_in(mem_ready_in),
    .mem_rvalid_in(mem_rvalid_in), .mem_rdata_in(mem_rdata_in));
  word_memory_model word_memory_model_i (
    .ref_clk_in(ref_clk_in), .mem_req_in(mem_req_out), .mem_ready_out(mem_ready_in),
    .mem_rvalid_out(mem_rvalid_in), .mem_rdata_out(mem_rdata_in));
  task check(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task results;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task put(int a, int v);
    word_memory_model_i.mem[a] = v[15:0];
    ref_mem[a] = v & 32'h0000FFFF;
  endtask : put
  // ----------------------------------------------------------------
  // One scan: model the operation, run it, compare the table
  // ----------------------------------------------------------------
  task run(word_table_pkg::table_op_t op, int len, int base, int opd);
    int c;
    int k;
    int dones;
    logic f;
    c = ref_mem[base];
    f = 1'b1;
    if (c == 0 || c > len) f = 1'b1;
    else if (op == word_table_pkg::OP_POP) begin
      ref_mem[opd] = ref_mem[base+1];
      for (k = 1; k < c; k++) ref_mem[base+k] = ref_mem[base+k+1];
      ref_mem[base] = c - 1;
      f = (c == 1);
    end else begin
      f = 1'b0;
      if (c < len) begin
        for (k = c; k > 0; k--) ref_mem[base+k+1] = ref_mem[base+k];
        ref_mem[base+1] = ref_mem[opd];
        ref_mem[base] = c + 1;
      end
    end
    @(negedge ref_clk_in);
    args_in = {op, len[7:0], base[15:0], opd[15:0]};
    scan_start_in = 1'b1;
    @(negedge ref_clk_in);
    scan_start_in = 1'b0;
    rung_enable_in = 1'b1;
    dones = 0;
    repeat (80 + 5 * len) begin
      @(negedge ref_clk_in);
      dones += int'(done_out);
    end
    if (dones == 0) begin
      n_fail++;
      results();
    end
    check("runs", 16'(dones), 16'h0001);
    check("flag", 16'(table_counter_zero_flag_out), 16'(f));
    scan_end_in = 1'b1;
    @(negedge ref_clk_in);
    scan_end_in = 1'b0;
    rung_enable_in = 1'b0;
    @(negedge ref_clk_in);
    check("flag end", 16'(table_counter_zero_flag_out), 16'h0000);
    for (k = 0; k <= len + 1; k++) begin
      check("table", word_memory_model_i.mem[base+k], 16'(ref_mem[base+k]));
    end
    check("operand", word_memory_model_i.mem[opd], 16'(ref_mem[opd]));
  endtask : run
  initial begin
    void'($urandom(32'h3080C962));
    for (i = 0; i < 520; i++) put(32'h0100 + i, $urandom);
    repeat (6) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    put(32'h0100, 4);
    repeat (6) run(word_table_pkg::OP_POP, 6, 32'h0100, 32'h0040);
    put(32'h0100, 7);
    run(word_table_pkg::OP_POP, 6, 32'h0100, 32'h0040);
    put(32'h0100, 2);
    for (i = 0; i < 5; i++) begin
      put(32'h0040, $urandom);
      run(word_table_pkg::OP_PUSH, 6, 32'h0100, 32'h0040);
    end
    put(32'h0100, 0);
    run(word_table_pkg::OP_PUSH, 6, 32'h0100, 32'h0040);
    put(32'h0100, 9);
    run(word_table_pkg::OP_PUSH, 6, 32'h0100, 32'h0040);
    put(32'h0100, 255);
    run(word_table_pkg::OP_PUSH, 255, 32'h0100, 32'h0040);
    run(word_table_pkg::OP_POP, 255, 32'h0100, 32'h0040);
    for (i = 0; i < 12; i++) begin
      n = 1 + $urandom % 8;
      put(32'h0100, $urandom % (n + 2));
      put(32'h0040, $urandom);
      run(word_table_pkg::table_op_t'($urandom % 2), n, 32'h0100, 32'h0040);
    end
    results();
  end
endmodule : word_table_push_pop_engine_test
`default_nettype wire
